// File: hdl/dcs_cfg.svh
// Constants for the command spacing and termination block.
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
`define DCS_ADDR_W 4
`define DCS_OFS_GAP 4'h0
`define DCS_OFS_TERM 4'h4
`define DCS_OFS_SEL 4'h8
`define DCS_OFS_STAT 4'hC
`define DCS_GAP_RESET 32'h00000000
`define DCS_TERM_RESET 32'h00000000
`define DCS_RMW_MSB 31
`define DCS_RMW_LSB 28
`define DCS_RTW_MSB 27
`define DCS_RTW_LSB 24
`define DCS_WWX_MSB 23
`define DCS_WWX_LSB 20
`define DCS_WWS_MSB 19
`define DCS_WWS_LSB 16
`define DCS_RRX_MSB 15
`define DCS_RRX_LSB 12
`define DCS_RRS_MSB 11
`define DCS_RRS_LSB 8
`define DCS_WRX_MSB 7
`define DCS_WRX_LSB 4
`define DCS_WRS_MSB 3
`define DCS_WRS_LSB 0
`define DCS_TERM_HI_POS 16
`define DCS_TERM_LO_POS 0
`define DCS_GAP_W 4
`define DCS_CNT_ONE 4'h1
`define DCS_CNT_MAX 4'hF
// Fewest edges between two accepted commands, set by the grant handshake.
`define DCS_CADENCE 2
`endif

// File: hdl/dcs_pkg.sv
// Types shared by the command spacing block.
package dcs_pkg;
  typedef enum logic [1:0] {DCS_NONE, DCS_READ, DCS_WRITE} dcs_cmd_t;
  typedef struct packed {
    logic valid;
    logic is_write;
    logic rmw;
    logic [2:0] cs;
  } dcs_req_t;
endpackage

// File: hdl/dcs_gap_timer.sv
// Elapsed-clock counter that says when a programmed gap has passed.
`timescale 1ns/10ps
`include "dcs_cfg.svh"
module dcs_gap_timer
  import dcs_pkg::*;
#(
  parameter int GW = `DCS_GAP_W
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic restart,
  input wire logic [GW-1:0] gap,
  output logic met
);
  logic [GW-1:0] elapsed;
  logic [GW-1:0] next_elapsed;
  if (GW < 1)
  begin : g_gw_check
    $error("dcs_gap_timer: GW must be at least 1");
  end
  // Counts clocks since the last restart and saturates at all ones.
  assign next_elapsed = restart ? GW'(1) : ((&elapsed) ? elapsed : elapsed + GW'(1));
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      elapsed <= '1;
    else
      elapsed <= next_elapsed;
  end
  // A zero gap is always met; otherwise the elapsed count must reach it.
  assign met = (gap == '0) || (elapsed >= gap);
endmodule

// File: hdl/dcs_top.sv
// Command spacing and on-die termination enable logic of a DDR controller.
// Notes on behaviour
// (R1) A read-modify-write waits at least the rmw gap between its read and its write.
// (R2) A write after a read waits at least the read-then-write gap, on any chip select.
// (R3) Writes to different chip selects are spaced by the cross-select write gap.
// (R4) Writes to the same chip select are spaced by the same-select write gap.
// (R5) Reads to different chip selects are spaced by the cross-select read gap.
// (R6) Reads to the same chip select are spaced by the same-select read gap.
// (R7) A read after a write to another chip select waits the cross-select write-read gap.
// (R8) A read after a write to the same chip select waits the same-select write-read gap.
// (R9) Bit 16 of the termination register enables termination on the selected chip select for reads.
// (R10) Bit 0 of the termination register enables termination on the selected chip select for writes.
// (R11) Each gap is tracked as clocks since the last relevant command and a zero gap adds no wait.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "dcs_cfg.svh"
module dcs_top
  import dcs_pkg::*;
#(
  parameter int CS_W = 3
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [`DCS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire dcs_req_t cmd_req,
  output logic cmd_grant,
  output logic cmd_issue_write,
  output logic [CS_W-1:0] cmd_issue_cs,
  output logic term_drive,
  output logic [CS_W-1:0] term_cs
);
  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (CS_W != 3)
  begin : g_cs_w_check
    $error("dcs_top: CS_W must match the request carrier width of 3");
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [31:0] ddr_command_gap_config;
  logic [31:0] ddr_termination_enable;
  logic [7:0] term_select_mask;
  logic [31:0] issue_count;
  logic [31:0] next_rdata;
  wire hit_gap = reg_addr == `DCS_OFS_GAP;
  wire hit_term = reg_addr == `DCS_OFS_TERM;
  wire hit_sel = reg_addr == `DCS_OFS_SEL;
  wire hit_stat = reg_addr == `DCS_OFS_STAT;
  wire [31:0] term_mask_w = (32'h00000001 << `DCS_TERM_HI_POS) | (32'h00000001 << `DCS_TERM_LO_POS);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ddr_command_gap_config <= `DCS_GAP_RESET;
      ddr_termination_enable <= `DCS_TERM_RESET;
      term_select_mask <= 8'h00;
    end
    else if (reg_write)
    begin
      if (hit_gap)
        ddr_command_gap_config <= reg_wdata;
      if (hit_term)
        ddr_termination_enable <= reg_wdata & term_mask_w;
      if (hit_sel)
        term_select_mask <= reg_wdata[7:0];
    end
  end

  // Unmapped addresses read as zero.
  assign next_rdata = !reg_read ? 32'h00000000 :
                      hit_gap ? ddr_command_gap_config :
                      hit_term ? ddr_termination_enable :
                      hit_sel ? {24'h000000, term_select_mask} :
                      hit_stat ? issue_count : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= next_rdata;
  end

  // ****************************************************************
  // Gap fields
  // ****************************************************************
  wire [3:0] rmw_gap_clocks = ddr_command_gap_config[`DCS_RMW_MSB:`DCS_RMW_LSB];
  wire [3:0] read_then_write_gap = ddr_command_gap_config[`DCS_RTW_MSB:`DCS_RTW_LSB];
  wire [3:0] write_write_cross_select_gap = ddr_command_gap_config[`DCS_WWX_MSB:`DCS_WWX_LSB];
  wire [3:0] write_write_same_select_gap = ddr_command_gap_config[`DCS_WWS_MSB:`DCS_WWS_LSB];
  wire [3:0] read_read_cross_select_gap = ddr_command_gap_config[`DCS_RRX_MSB:`DCS_RRX_LSB];
  wire [3:0] read_read_same_select_gap = ddr_command_gap_config[`DCS_RRS_MSB:`DCS_RRS_LSB];
  wire [3:0] write_read_cross_select_gap = ddr_command_gap_config[`DCS_WRX_MSB:`DCS_WRX_LSB];
  wire [3:0] write_read_same_select_gap = ddr_command_gap_config[`DCS_WRS_MSB:`DCS_WRS_LSB];

  // ****************************************************************
  // History of the last command
  // ****************************************************************
  logic last_valid;
  logic last_write;
  logic last_rmw_read;
  logic [CS_W-1:0] last_cs;
  logic ok_all;
  // The grant reaches the requester one cycle after acceptance, so a request that still
  // stands while its grant shows is the one just taken and must not be taken twice.
  wire fire = cmd_req.valid && ok_all && !cmd_grant; // [R11]
  wire same_cs = last_cs == cmd_req.cs;
  wire last_read = last_valid && !last_write;
  wire last_wr = last_valid && last_write;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      last_valid <= 1'b0;
      last_write <= 1'b0;
      last_rmw_read <= 1'b0;
      last_cs <= '0;
    end
    else if (fire)
    begin
      last_valid <= 1'b1;
      last_write <= cmd_req.is_write;
      last_rmw_read <= cmd_req.rmw && !cmd_req.is_write;
      last_cs <= cmd_req.cs;
    end
  end

  // ****************************************************************
  // Gap timers, one per constraint
  // ****************************************************************
  logic met_rd;
  logic met_wr;
  logic met_rtw;
  logic met_rmw;
  logic met_wwx;
  logic met_wws;
  logic met_rrx;
  logic met_rrs;
  logic met_wrx;
  logic met_wrs;
  wire fire_rd = fire && !cmd_req.is_write;
  wire fire_wr = fire && cmd_req.is_write;

  // Read timers restart on every accepted read and write timers on every accepted write.
  // Each one compares the clocks since that command with one programmed gap.
  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_rtw (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_rd),
    .gap(read_then_write_gap),
    .met(met_rtw)
  ); // [R2] [R11]

  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_rmw (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_rd),
    .gap(rmw_gap_clocks),
    .met(met_rmw)
  ); // [R1]

  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_rrx (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_rd),
    .gap(read_read_cross_select_gap),
    .met(met_rrx)
  ); // [R5]

  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_rrs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_rd),
    .gap(read_read_same_select_gap),
    .met(met_rrs)
  ); // [R6]

  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_wwx (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_wr),
    .gap(write_write_cross_select_gap),
    .met(met_wwx)
  ); // [R3]

  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_wws (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_wr),
    .gap(write_write_same_select_gap),
    .met(met_wws)
  ); // [R4]

  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_wrx (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_wr),
    .gap(write_read_cross_select_gap),
    .met(met_wrx)
  ); // [R7]

  dcs_gap_timer #(
    .GW(`DCS_GAP_W)
  ) u_wrs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(fire_wr),
    .gap(write_read_same_select_gap),
    .met(met_wrs)
  ); // [R8]

  // ****************************************************************
  // Issue decision
  // ****************************************************************
  // Only the constraint for the last command's kind and select applies, plus the rmw gap for an rmw write after an rmw read.
  wire ok_w_after_r = !last_read || (met_rtw && (!(cmd_req.rmw && last_rmw_read) || met_rmw)); // [R1] [R2]
  wire ok_w_after_w = !last_wr || (same_cs ? met_wws : met_wwx); // [R3] [R4]
  wire ok_r_after_r = !last_read || (same_cs ? met_rrs : met_rrx); // [R5] [R6]
  wire ok_r_after_w = !last_wr || (same_cs ? met_wrs : met_wrx); // [R7] [R8]
  assign met_wr = ok_w_after_r && ok_w_after_w;
  assign met_rd = ok_r_after_r && ok_r_after_w;
  assign ok_all = cmd_req.is_write ? met_wr : met_rd; // [R11]

  // ****************************************************************
  // Issue outputs and termination
  // ****************************************************************
  wire term_hi = ddr_termination_enable[`DCS_TERM_HI_POS];
  wire term_lo = ddr_termination_enable[`DCS_TERM_LO_POS];
  wire sel_hit = term_select_mask[cmd_req.cs];
  wire next_term = fire && sel_hit && (cmd_req.is_write ? term_lo : term_hi); // [R9] [R10]

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_grant <= 1'b0;
      cmd_issue_write <= 1'b0;
      cmd_issue_cs <= '0;
      term_drive <= 1'b0;
      term_cs <= '0;
      issue_count <= 32'h00000000;
    end
    else
    begin
      cmd_grant <= fire;
      cmd_issue_write <= fire && cmd_req.is_write;
      cmd_issue_cs <= fire ? cmd_req.cs : cmd_issue_cs;
      term_drive <= next_term;
      term_cs <= fire ? cmd_req.cs : term_cs;
      issue_count <= fire ? issue_count + 32'h00000001 : issue_count;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // These counters run apart from the gap timers, so a fault in a timer cannot hide itself.
  logic [3:0] since_rd;
  logic [3:0] since_wr;
  logic ever_rd;
  logic ever_wr;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      since_rd <= 4'hF;
      since_wr <= 4'hF;
      ever_rd <= 1'b0;
      ever_wr <= 1'b0;
    end
    else
    begin
      since_rd <= fire_rd ? 4'h1 : ((since_rd == 4'hF) ? since_rd : since_rd + 4'h1);
      since_wr <= fire_wr ? 4'h1 : ((since_wr == 4'hF) ? since_wr : since_wr + 4'h1);
      ever_rd <= ever_rd || fire_rd;
      ever_wr <= ever_wr || fire_wr;
    end
  end

  chk_rmw_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
    (fire_wr && cmd_req.rmw && last_rmw_read) |-> (since_rd >= rmw_gap_clocks))
    else $error("rmw write issued before its gap");
  chk_rtw_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
    (fire_wr && last_read) |-> (since_rd >= read_then_write_gap))
    else $error("write after read issued too early");
  chk_wwx_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
    (fire_wr && last_wr && !same_cs) |-> (since_wr >= write_write_cross_select_gap))
    else $error("cross-select write pair too close");
  chk_wws_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
    (fire_wr && last_wr && same_cs) |-> (since_wr >= write_write_same_select_gap))
    else $error("same-select write pair too close");
  chk_rrx_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R5]
    (fire_rd && last_read && !same_cs) |-> (since_rd >= read_read_cross_select_gap))
    else $error("cross-select read pair too close");
  chk_rrs_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R6]
    (fire_rd && last_read && same_cs) |-> (since_rd >= read_read_same_select_gap))
    else $error("same-select read pair too close");
  chk_wrx_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
    (fire_rd && last_wr && !same_cs) |-> (since_wr >= write_read_cross_select_gap))
    else $error("cross-select read after write too early");
  chk_wrs_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
    (fire_rd && last_wr && same_cs) |-> (since_wr >= write_read_same_select_gap))
    else $error("same-select read after write too early");
  chk_term_read: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
    fire_rd |=> (term_drive == ($past(term_hi) && $past(sel_hit))))
    else $error("read termination wrong");
  chk_term_write: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
    fire_wr |=> (term_drive == ($past(term_lo) && $past(sel_hit))))
    else $error("write termination wrong");
  chk_zero_free: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
    (ddr_command_gap_config == 32'h00000000 && cmd_req.valid && !cmd_grant) |=> cmd_grant)
    else $error("zero gaps still stalled a command");
  chk_grant_single: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
    cmd_grant |=> !cmd_grant)
    else $error("grant stood for more than one cycle");
  chk_issue_kind: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
    fire |=> (cmd_grant && (cmd_issue_write == $past(cmd_req.is_write))
      && (cmd_issue_cs == $past(cmd_req.cs))))
    else $error("issued command differs from the one accepted");
  chk_history_kept: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
    last_valid == (ever_rd || ever_wr))
    else $error("command history lost");
endmodule

// File: tb/dcs_sdram_model.sv
// Far-side memory model that times the spacing of the commands it receives.
`timescale 1ns/10ps
module dcs_sdram_model
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cmd_grant,
  input wire logic [2:0] cmd_issue_cs,
  output logic [7:0] gap_seen,
  output logic [2:0] last_cs
);
  logic [7:0] since;

  // While a command is on the bus, gap_seen gives the edges since the one before.
  assign gap_seen = since + 8'h01;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      since <= 8'hFE;
      last_cs <= 3'h0;
    end
    else if (cmd_grant)
    begin
      since <= 8'h00;
      last_cs <= cmd_issue_cs;
    end
    else if (since != 8'hFE)
    begin
      since <= since + 8'h01;
    end
  end
endmodule

// File: tb/ddr_command_spacing_tb_top.sv
// Self-checking testbench for the command spacing and termination block.
`timescale 1ns/10ps
`include "dcs_cfg.svh"
module ddr_command_spacing_tb_top
  import dcs_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  dcs_req_t cmd_req = '0;
  logic cmd_grant, cmd_issue_write, term_drive;
  logic [2:0] cmd_issue_cs, term_cs, last_cs;
  logic [7:0] gap_seen;
  logic [31:0] cfg, ten, msk;
  int errors = 0;
  int total_checks = 0;
  int issued = 0;
  dcs_req_t pa [9] = '{6'h20, 6'h20, 6'h30, 6'h30, 6'h21, 6'h21, 6'h30, 6'h30, 6'h28};
  dcs_req_t pb [9] = '{6'h20, 6'h21, 6'h30, 6'h32, 6'h31, 6'h33, 6'h20, 6'h25, 6'h38};
  int pk [9] = '{2, 3, 4, 5, 6, 6, 0, 1, 7};

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  dcs_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .cmd_req(cmd_req),
    .cmd_grant(cmd_grant), .cmd_issue_write(cmd_issue_write), .cmd_issue_cs(cmd_issue_cs),
    .term_drive(term_drive), .term_cs(term_cs));

  dcs_sdram_model mem (.clk_sys(clk_sys), .rstn(rstn), .cmd_grant(cmd_grant),
    .cmd_issue_cs(cmd_issue_cs), .gap_seen(gap_seen), .last_cs(last_cs));

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Every task starts and ends in the time step of a rising edge and drives by non-blocking assignment.
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Read data stand only in the cycle after the strobe and are sampled at the edge that ends it.
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    check("reg_rdata", reg_rdata, exp);
  endtask

  // Waits until the grant of r is sampled high at a rising edge, then checks what was issued.
  task automatic take_grant(input dcs_req_t r, input int g);
    int n;
    logic t;
    n = 0;
    @(posedge clk_sys);
    while (cmd_grant !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 40)
    begin
      errors++;
      complete_run();
    end
    issued++;
    t = (r.is_write ? ten[`DCS_TERM_LO_POS] : ten[`DCS_TERM_HI_POS]) & msk[r.cs];
    check("cmd_issue_write", {31'h0, cmd_issue_write}, {31'h0, r.is_write});
    check("cmd_issue_cs", {29'h0, cmd_issue_cs}, {29'h0, r.cs});
    check("term_cs", {29'h0, term_cs}, {29'h0, r.cs});
    check("term_drive", {31'h0, term_drive}, {31'h0, t});
    if (g > 0)
      check("gap_seen", {24'h0, gap_seen}, g);
  endtask

  task automatic run_pairs;
    int i;
    int g;
    for (i = 0; i < 9; i++)
    begin
      g = cfg[pk[i]*4 +: 4];
      if (i == 8 && int'(cfg[27:24]) > g)
        g = cfg[27:24];
      if (g < `DCS_CADENCE)
        g = `DCS_CADENCE;
      cmd_req <= pa[i];
      take_grant(pa[i], 0);
      cmd_req <= pb[i];
      take_grant(pb[i], g);
      cmd_req <= '0;
      repeat (18) @(posedge clk_sys);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_rd(`DCS_OFS_GAP, `DCS_GAP_RESET);
    reg_rd(`DCS_OFS_TERM, `DCS_TERM_RESET);
    reg_wr(`DCS_OFS_TERM, 32'hFFFFFFFF);
    reg_rd(`DCS_OFS_TERM, 32'h00010001);
    @(posedge clk_sys);
    check("reg_rdata idle", reg_rdata, 32'h0);
    reg_wr(4'h2, 32'h12345678);
    reg_rd(4'h2, 32'h0);
    $display("Test registers done");
    cfg = 32'h97654382;
    ten = 32'h00010000;
    msk = 32'h00000001;
    reg_wr(`DCS_OFS_GAP, cfg);
    reg_wr(`DCS_OFS_TERM, ten);
    reg_wr(`DCS_OFS_SEL, msk);
    reg_rd(`DCS_OFS_GAP, cfg);
    run_pairs();
    $display("Test programmed gaps done");
    rstn <= 1'b0;
    issued = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_rd(`DCS_OFS_GAP, `DCS_GAP_RESET);
    reg_rd(`DCS_OFS_STAT, 32'h0);
    $display("Test mid-run reset done");
    cfg = 32'h0;
    ten = 32'h00000001;
    msk = 32'h00000021;
    reg_wr(`DCS_OFS_GAP, cfg);
    reg_wr(`DCS_OFS_TERM, ten);
    reg_wr(`DCS_OFS_SEL, msk);
    run_pairs();
    $display("Test zero gaps done");
    reg_wr(`DCS_OFS_STAT, 32'h0);
    reg_rd(`DCS_OFS_STAT, issued);
    check("last_cs", {29'h0, last_cs}, 32'h0);
    $display("Test status done");
    complete_run();
  end
endmodule
